// *** hw/asb_dev.sv ***
// Converter end: conversion control, busy indicator and serial transfer
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
`timescale 1ns/1ns
module asb_dev #(
   parameter int CONV_CYCLES = asb_pkg::CONV_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Link
   asb_link_if.dev_mp       link,
   // Converter core side
   input  wire logic [15:0] sample_data,
   output logic             converting,
   output logic [13:0]      cfg_word,
   output logic             cfg_update
);
   typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_XFER} asb_dev_state_t;

   if (CONV_CYCLES < 1 || CONV_CYCLES > 4096) begin : g_bad_conv
      $error("asb_dev: CONV_CYCLES out of range");
   end

   // ---------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ---------------------------------------------------------------------
   logic [2:0] pins_s;
   logic       start_s;
   logic       sck_s;
   logic       din_s;
   logic       start_d_r;
   logic       sck_d_r;
   logic       start_rise;
   logic       sck_fall;
   logic       sck_rise;

   asb_sync #(
      .W       (3),
      .RST_VAL (8'h02)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       ({link.conversion_start_pin, link.sclk, link.cfg_in}),
      .q       (pins_s)
   );

   assign start_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign din_s = pins_s[0];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_d_r <= 1'b0;
         sck_d_r   <= 1'b1;
      end else begin
         start_d_r <= start_s;
         sck_d_r   <= sck_s;
      end
   end

   assign start_rise = start_s & ~start_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   assign sck_rise = sck_s & ~sck_d_r;

   // ---------------------------------------------------------------------
   // Conversion sequencing
   // ---------------------------------------------------------------------
   asb_dev_state_t state_r;
   logic [12:0]    conv_cnt_r;
   logic           conv_done;

   assign conv_done  = (state_r == ST_CONV) && (conv_cnt_r == 13'(CONV_CYCLES - 1));
   assign converting = (state_r == ST_CONV);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_ACQ;
      end else begin
         unique case (state_r)
            ST_ACQ, ST_XFER: begin
               if (start_rise) begin
                  state_r <= ST_CONV;
               end
            end
            ST_CONV: begin
               // Start pin not looked at until done
               if (conv_done) begin
                  state_r <= ST_XFER;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt_r <= '0;
      end else if (state_r != ST_CONV) begin
         conv_cnt_r <= '0;
      end else begin
         conv_cnt_r <= conv_cnt_r + 13'd1;
      end
   end

   // ---------------------------------------------------------------------
   // Configuration capture
   // ---------------------------------------------------------------------
   logic [13:0]            cfg_r;
   logic [13:0]            cfg_used_r;
   logic [13:0]            cfg_sh_r;
   logic [asb_pkg::CNT_W-1:0] rise_cnt_r;
   logic                   cfg_upd_r;

   assign cfg_word   = cfg_r;
   assign cfg_update = cfg_upd_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_cnt_r <= '0;
         cfg_sh_r   <= '0;
         cfg_r      <= asb_pkg::CFG_RST;
         cfg_upd_r  <= 1'b0;
      end else begin
         cfg_upd_r <= 1'b0;
         if (conv_done) begin
            rise_cnt_r <= '0;
         end else if (state_r == ST_XFER && !start_rise && sck_rise &&
                      rise_cnt_r < asb_pkg::CNT_W'(asb_pkg::CFG_W)) begin
            cfg_sh_r   <= {cfg_sh_r[12:0], din_s};
            rise_cnt_r <= rise_cnt_r + 5'd1;
            // First bit set marks a write; applied only when all 14 arrive
            if (rise_cnt_r == asb_pkg::CNT_W'(asb_pkg::CFG_W - 1) && cfg_sh_r[12]) begin
               cfg_r     <= {cfg_sh_r[12:0], din_s};
               cfg_upd_r <= 1'b1;
            end
         end
      end
   end

   // Settings in force for the conversion being started
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_used_r <= asb_pkg::CFG_RST;
      end else if (start_rise && state_r != ST_CONV) begin
         cfg_used_r <= cfg_r;
      end
   end

   // ---------------------------------------------------------------------
   // Result output
   // ---------------------------------------------------------------------
   logic [asb_pkg::SH_W-1:0]  out_sh_r;
   logic [asb_pkg::CNT_W-1:0] fall_cnt_r;
   logic [asb_pkg::CNT_W-1:0] last_fall;
   logic                      armed_r;
   logic                      res_bit_r;
   logic                      oe_r;

   assign last_fall   = cfg_used_r[asb_pkg::CFG_RB_BIT] ?
                        asb_pkg::CNT_W'(asb_pkg::LAST_FALL_RB) :
                        asb_pkg::CNT_W'(asb_pkg::LAST_FALL);
   assign link.res_bit = res_bit_r;
   assign link.res_oe  = oe_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_sh_r   <= '0;
         fall_cnt_r <= '0;
         armed_r    <= 1'b0;
         res_bit_r  <= 1'b0;
         oe_r       <= 1'b0;
      end else if (start_rise && state_r != ST_CONV) begin
         oe_r    <= 1'b0;
         armed_r <= 1'b0;
      end else if (conv_done) begin
         // Old result replaced here whether read or not
         out_sh_r   <= {sample_data, cfg_used_r};
         fall_cnt_r <= '0;
         res_bit_r  <= 1'b0;
         oe_r       <= ~start_s;
         armed_r    <= ~start_s;
      end else if (state_r == ST_XFER && armed_r && sck_fall) begin
         fall_cnt_r <= fall_cnt_r + 5'd1;
         if (fall_cnt_r + 5'd1 == last_fall) begin
            oe_r    <= 1'b0;
            armed_r <= 1'b0;
         end else begin
            // Falls 1..16 give result, 17..30 give config
            res_bit_r <= out_sh_r[asb_pkg::SH_W-1];
            out_sh_r <= {out_sh_r[asb_pkg::SH_W-2:0], 1'b0};
         end
      end
      // Otherwise the last bit keeps being driven
   end
endmodule

// *** hw/asb_host.sv ***
// Host end: starts conversions, waits for data-ready, clocks the transfer
`timescale 1ns/1ns
module asb_host #(
   parameter int HALF = asb_pkg::SCLK_HALF_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Link
   asb_link_if.host_mp      link,
   // User request
   input  wire logic        start,
   input  wire logic        readback_en,
   input  wire logic        cfg_wr,
   input  wire logic [13:0] cfg_data,
   // User answer
   output logic [15:0]      result,
   output logic [13:0]      cfg_back,
   output logic             done,
   output logic             busy
);
   typedef enum logic [2:0] {H_IDLE, H_CNV, H_WAIT, H_XFER, H_DONE} asb_host_state_t;

   if (HALF < 4 || HALF > 64) begin : g_bad_half
      $error("asb_host: HALF out of range");
   end

   // ---------------------------------------------------------------------
   // Data-ready line synchroniser
   // ---------------------------------------------------------------------
   logic line_s;

   asb_sync #(
      .W       (1),
      .RST_VAL (8'h01)
   ) u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .d       (link.serial_result_out),
      .q       (line_s)
   );

   // ---------------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------------
   asb_host_state_t state_r;
   logic [7:0]      ph_r;
   logic [4:0]      k_r;
   logic [4:0]      n_r;
   logic            pin_r;
   logic            sck_r;
   logic            din_r;
   logic            wr_r;
   logic [13:0]     cfg_sh_r;
   logic [29:0]     rx_r;
   logic            done_r;

   assign link.conversion_start_pin = pin_r;
   assign link.sclk                 = sck_r;
   assign link.cfg_in               = din_r;
   assign busy                      = (state_r != H_IDLE);
   assign done                      = done_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r  <= H_IDLE;
         ph_r     <= '0;
         k_r      <= '0;
         n_r      <= 5'(asb_pkg::LAST_FALL);
         pin_r    <= 1'b0;
         sck_r    <= 1'b1;
         din_r    <= 1'b0;
         wr_r     <= 1'b0;
         cfg_sh_r <= '0;
         rx_r     <= '0;
         result   <= '0;
         cfg_back <= '0;
         done_r   <= 1'b0;
      end else begin
         done_r <= 1'b0;
         ph_r   <= ph_r + 8'd1;
         unique case (state_r)
            H_IDLE: begin
               if (start) begin
                  state_r  <= H_CNV;
                  ph_r     <= '0;
                  pin_r    <= 1'b1;
                  n_r      <= readback_en ? 5'(asb_pkg::LAST_FALL_RB) :
                                            5'(asb_pkg::LAST_FALL);
                  wr_r     <= cfg_wr;
                  cfg_sh_r <= cfg_data;
               end
            end
            H_CNV: begin
               if (ph_r == 8'(asb_pkg::START_HIGH_CYC - 1)) begin
                  pin_r   <= 1'b0;
                  state_r <= H_WAIT;
                  ph_r    <= '0;
               end
            end
            H_WAIT: begin
               // Falling line after release means data ready
               if (ph_r >= 8'(asb_pkg::WAIT_GUARD) && !line_s) begin
                  state_r <= H_XFER;
                  ph_r    <= '0;
                  k_r     <= 5'd1;
                  sck_r   <= 1'b0;
                  din_r   <= wr_r & cfg_sh_r[13];
               end
            end
            H_XFER: begin
               if (ph_r == 8'(HALF - 1)) begin
                  sck_r <= 1'b1;
               end
               if (ph_r == 8'(2 * HALF - 1)) begin
                  if (k_r == n_r) begin
                     state_r <= H_DONE;
                  end else begin
                     rx_r     <= {rx_r[28:0], line_s};
                     cfg_sh_r <= {cfg_sh_r[12:0], 1'b0};
                     din_r    <= wr_r & cfg_sh_r[12];
                     k_r      <= k_r + 5'd1;
                     ph_r     <= '0;
                     sck_r    <= 1'b0;
                  end
               end
            end
            H_DONE: begin
               din_r   <= 1'b0;
               done_r  <= 1'b1;
               state_r <= H_IDLE;
               if (n_r == 5'(asb_pkg::LAST_FALL_RB)) begin
                  result   <= rx_r[29:14];
                  cfg_back <= rx_r[13:0];
               end else begin
                  result   <= rx_r[15:0];
                  cfg_back <= '0;
               end
            end
            default: begin
               state_r <= H_IDLE;
            end
         endcase
      end
   end
endmodule

// *** hw/asb_link_if.sv ***
// Serial link between host and converter, with pull-up on the result line
`timescale 1ns/1ns
interface asb_link_if;
   logic conversion_start_pin;
   logic sclk;
   logic cfg_in;
   logic res_bit;
   logic res_oe;
   wire  serial_result_out;

   // Pull-up to the interface supply while released
   assign serial_result_out = res_oe ? res_bit : 1'b1;

   modport dev_mp (
      input  conversion_start_pin,
      input  sclk,
      input  cfg_in,
      output res_bit,
      output res_oe
   );
   modport host_mp (
      output conversion_start_pin,
      output sclk,
      output cfg_in,
      input  serial_result_out
   );
endinterface

// *** hw/asb_pkg.sv ***
// Shared constants for the busy-indicator converter link
package asb_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS  = 2200;
   localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC = 4;
   localparam int START_HIGH_CYC = 4;
   localparam int WAIT_GUARD    = 4;

   // ----------------------------------------------------------------
   // Word layout and counts
   // ----------------------------------------------------------------
   localparam int RES_W        = 16;
   localparam int CFG_W        = 14;
   localparam int SH_W         = RES_W + CFG_W;
   localparam int CFG_RB_BIT   = 0;
   localparam int LAST_FALL    = 17;
   localparam int LAST_FALL_RB = 31;
   localparam int CNT_W        = 5;
   localparam logic [13:0] CFG_RST = 14'h0000;
endpackage

// *** hw/asb_sync.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module asb_sync #(
   parameter int         W       = 1,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   if (W < 1 || W > 8) begin : g_bad_w
      $error("asb_sync: W out of range");
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL[W-1:0];
         q      <= RST_VAL[W-1:0];
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// *** tb/asb_link_chk.sv ***
// Concurrent checks on the host-to-converter serial link
`timescale 1ns/1ns
module asb_link_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Link signals
   input wire logic conversion_start_pin,
   input wire logic sclk,
   input wire logic cfg_in,
   input wire logic res_bit,
   input wire logic res_oe,
   input wire logic serial_result_out
);
   logic [5:0] fall_cnt_r;
   logic       pend_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Falls since data-ready, start pending
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) fall_cnt_r <= 6'h00;
      else if ($rose(res_oe)) fall_cnt_r <= 6'h00;
      else if ($fell(sclk)) fall_cnt_r <= fall_cnt_r + 6'h01;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) pend_r <= 1'b0;
      else if ($rose(conversion_start_pin)) pend_r <= 1'b1;
      else if ($rose(res_oe)) pend_r <= 1'b0;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_IDLE_HIGH: assert property (pend_r |-> sclk)
      else $error("serial clock not idle high while converting");
   AST_START_REL: assert property ($rose(conversion_start_pin) |-> ##[1:6] !res_oe)
      else $error("output not released after start");
   AST_CONV_RUN: assert property ($rose(conversion_start_pin) |-> ##6 !res_oe [*8])
      else $error("output driven during conversion");
   AST_PIN_LOW: assert property ($rose(res_oe) |-> !conversion_start_pin)
      else $error("data-ready with start pin high");
   AST_READY_LOW: assert property ($rose(res_oe) |-> !res_bit && !serial_result_out)
      else $error("data-ready level not low");
   AST_READY_TIME: assert property ($rose(conversion_start_pin) |-> ##[56:66] res_oe)
      else $error("conversion did not end in time");
   AST_REL_COUNT: assert property ($fell(res_oe) && !pend_r |->
      fall_cnt_r == 6'h11 || fall_cnt_r == 6'h1f)
      else $error("output released at wrong falling edge");
   AST_RB_END: assert property ($rose(fall_cnt_r == 6'h1f) |-> ##[1:6] !res_oe)
      else $error("output not released after last readback edge");
   AST_MAX_FALL: assert property (res_oe |-> fall_cnt_r <= 6'h1f)
      else $error("more falling edges than a frame holds");
   AST_CFG_EDGE: assert property ($changed(cfg_in) |-> $fell(sclk))
      else $error("config bit changed away from a falling clock edge");

   cover property ($fell(res_oe) && fall_cnt_r == 6'h11);
   cover property ($fell(res_oe) && fall_cnt_r == 6'h1f);
   cover property ($fell(res_oe) && pend_r);
endmodule

// *** tb/tb.sv ***
// Bench: host and converter ends joined, plus a second converter driven by the bench
`timescale 1ns/1ns
module tb;
   logic        sys_clk     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        start       = 1'b0;
   logic        readback_en = 1'b0;
   logic        cfg_wr      = 1'b0;
   logic [13:0] cfg_data    = 14'h0000;
   logic [15:0] sample_data = 16'h0000;
   logic [15:0] sample_b    = 16'h0000;
   logic [13:0] cfg_now     = asb_pkg::CFG_RST;
   logic [13:0] cfg_b_exp   = asb_pkg::CFG_RST;
   logic [15:0] result, sd;
   logic [13:0] cfg_back, cfg_word, cfg_word_b, cd, used;
   logic        done, busy, converting, converting_b, cfg_update, cfg_update_b, rb, wr;
   int          err_total, check_count, cyc, upd_cnt, upd_b, upd_exp;
   logic [1:0]  hc_ctl [5] = '{2'b01, 2'b00, 2'b11, 2'b11, 2'b10};
   logic [13:0] hc_cfg [5] = '{14'h2001, 14'h0000, 14'h1fff, 14'h2aaa, 14'h0000};
   logic [15:0] hc_sd  [5] = '{16'hffff, 16'h8001, 16'h0000, 16'h7ffe, 16'h1234};

   asb_link_if lk ();
   asb_link_if lk_b ();

   always #20 sys_clk = ~sys_clk;

   asb_dev i_asb_dev (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk.dev_mp),
      .sample_data(sample_data), .converting(converting), .cfg_word(cfg_word),
      .cfg_update(cfg_update));
   asb_dev i_asb_dev_b (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk_b.dev_mp),
      .sample_data(sample_b), .converting(converting_b), .cfg_word(cfg_word_b),
      .cfg_update(cfg_update_b));
   asb_host i_asb_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(lk.host_mp),
      .start(start), .readback_en(readback_en), .cfg_wr(cfg_wr), .cfg_data(cfg_data),
      .result(result), .cfg_back(cfg_back), .done(done), .busy(busy));
   asb_link_chk i_asb_link_chk (.sys_clk(sys_clk), .rst_n(rst_n),
      .conversion_start_pin(lk.conversion_start_pin), .sclk(lk.sclk), .cfg_in(lk.cfg_in),
      .res_bit(lk.res_bit), .res_oe(lk.res_oe), .serial_result_out(lk.serial_result_out));

   // ----------------------------------------
   // Cycle limit and update pulse counts
   // ----------------------------------------
   always @(negedge sys_clk) begin
      cyc++;
      if (cfg_update === 1'b1) upd_cnt++;
      if (cfg_update_b === 1'b1) upd_b++;
      if (cyc == 20000) begin
         err_total++;
         $display("Error run_time expected done seen hang");
         end_of_test();
      end
   end

   // Readback of a released line shows the pull-up
   function automatic logic [13:0] exp_back(logic r, logic [13:0] u);
      if (!r) return 14'h0000;
      return u[asb_pkg::CFG_RB_BIT] ? u : 14'h3fff;
   endfunction

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic xfer();
      int n;
      n = 0;
      @(posedge sys_clk);
      sample_data <= sd;
      readback_en <= rb;
      cfg_wr      <= wr;
      cfg_data    <= cd;
      start       <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      @(negedge sys_clk);
      chk("busy", 16'h0001, 16'(busy));
      do begin
         @(negedge sys_clk);
         n++;
      end while (done !== 1'b1 && n < 3000);
      chk("done", 16'h0001, 16'(done));
      chk("busy_end", 16'h0000, 16'(busy));
   endtask

   // Bench acts as host on the second link
   task automatic dev_b(logic hi, int nr, logic [13:0] c);
      logic [15:0] got;
      got = 16'h0000;
      if (nr >= 14 && c[13]) cfg_b_exp = c;
      @(posedge sys_clk);
      sample_b <= 16'($urandom);
      lk_b.conversion_start_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      lk_b.conversion_start_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      lk_b.conversion_start_pin <= hi;
      @(negedge sys_clk);
      chk("converting_b_on", 16'h0001, 16'(converting_b));
      repeat (56) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("converting_b", 16'h0000, 16'(converting_b));
      chk("ready_b", 16'(hi), 16'(lk_b.serial_result_out));
      for (int k = 0; k < nr; k++) begin
         @(posedge sys_clk);
         lk_b.sclk   <= 1'b0;
         lk_b.cfg_in <= c[13];
         c = c << 1;
         repeat (4) @(posedge sys_clk);
         lk_b.sclk <= 1'b1;
         repeat (3) @(posedge sys_clk);
         @(negedge sys_clk);
         got = {got[14:0], lk_b.serial_result_out};
      end
      repeat (20) @(negedge sys_clk);
      if (nr == 16) begin
         chk("data_b", sample_b, got);
         chk("held_b", 16'(sample_b[0]), 16'(lk_b.serial_result_out));
      end
      chk("cfg_word_b", 16'(cfg_b_exp), 16'(cfg_word_b));
      @(posedge sys_clk);
      lk_b.conversion_start_pin <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("Checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h5a4b_6107));
      lk_b.conversion_start_pin = 1'b0;
      lk_b.sclk = 1'b1;
      lk_b.cfg_in = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         if (i < 5) begin
            {rb, wr} = hc_ctl[i];
            cd = hc_cfg[i];
            sd = hc_sd[i];
         end else begin
            rb = 1'($urandom);
            wr = 1'($urandom);
            cd = 14'($urandom);
            sd = 16'($urandom);
         end
         used = cfg_now;
         xfer();
         chk("result", sd, result);
         chk("cfg_back", 16'(exp_back(rb, used)), 16'(cfg_back));
         if (wr && cd[13]) begin
            cfg_now = cd;
            upd_exp++;
         end
         chk("cfg_word", 16'(cfg_now), 16'(cfg_word));
         chk("converting", 16'h0000, 16'(converting));
      end
      dev_b(1'b1, 0, 14'h0000);
      dev_b(1'b0, 10, 14'h2345);
      dev_b(1'b0, 16, 14'h2344);
      chk("updates", 16'(upd_exp), 16'(upd_cnt));
      chk("updates_b", 16'h0001, 16'(upd_b));
      end_of_test();
   end
endmodule
